// ---- periph_bus_seq_pkg.sv ----
/*
 * periph_bus_seq_pkg: shared constants for the peripheral bus and dram cycle sequencer.
 * assumes the system clock is 50 MHz and the bus clock is a divided enable.
 */
package periph_bus_seq_pkg;
	// ==========================================================
	// clocking
	localparam int unsigned   SYS_CLK_HZ        = 50_000_000;
	localparam logic [2:0]    BCLK_DIV_RESET    = 3'h2;
	localparam logic [2:0]    BCLK_DIV_MIN      = 3'h2;
	// ==========================================================
	// widths
	localparam int unsigned   ADDR_W            = 16;
	localparam int unsigned   DRAM_ADDR_W       = 10;
	localparam int unsigned   DRAM_DQ_W         = 16;
	localparam int unsigned   DATA_W            = 16;
	localparam int unsigned   CS_W              = 4;
	// ==========================================================
	// dram width codes
	localparam logic [1:0]    DRAM_W4           = 2'h0;
	localparam logic [1:0]    DRAM_W8           = 2'h1;
	localparam logic [1:0]    DRAM_W16          = 2'h2;
	// ==========================================================
	// sequencer states
	typedef enum logic [3:0] {
		ST_IDLE     = 4'b0000,
		ST_IO_SETUP = 4'b0001,
		ST_IO_STRB1 = 4'b0010,
		ST_IO_STRB2 = 4'b0011,
		ST_IO_HOLD  = 4'b0100,
		ST_DR_ROW   = 4'b0101,
		ST_DR_RAS   = 4'b0110,
		ST_DR_COL   = 4'b0111,
		ST_DR_CAS   = 4'b1000,
		ST_DR_LATCH = 4'b1001,
		ST_DR_PRE   = 4'b1010,
		ST_DR_END   = 4'b1011
	} seq_state_t;
endpackage

// ---- periph_bus_dram_cycle_seq.sv ----
/*
 * periph_bus_dram_cycle_seq: peripheral bus read/write cycles and dram page mode reads.
 * assumes requests come from logic on clk_sys_i; pin inputs are asynchronous.
 */
`timescale 1ns/10ps
`default_nettype none

// Operation
// - decoded chip select goes active one bus clock before the strobe
// - read strobe held active for two bus clocks
// - chip select held one bus clock after read strobe release
// - with auto step on, address advances one bus clock after read strobe release
// - write strobe held active for two bus clocks
// - write data driven one bus clock after chip select asserts
// - write data stays driven one bus clock after write strobe release
// - chip select held one bus clock after write strobe release
// - with auto step on, address advances one bus clock after write strobe release
// - dram read: row address first, read strobe one bus clock later
// - row strobe asserts one bus clock after row address valid
// - column address replaces row one bus clock after row strobe
// - column strobe asserts one bus clock after column address valid
// - one bus clock after column strobe: capture data, step column
// - column strobe released one bus clock after capture and step
// - column strobe stays high one bus clock between burst accesses
// - read strobe released within one system clock after both address strobes
// - dram width 4, or width 8 when wide, completes as page mode burst; width 16 is one access
// - burst applies to dma and host dram accesses alike
module periph_bus_dram_cycle_seq
	import periph_bus_seq_pkg::*;
(
	input  wire logic                   clk_sys_i,
	input  wire logic                   resetn_i,
	input  wire logic [2:0]             bclk_div_i,
	input  wire logic                   io_req_i,
	input  wire logic                   io_write_i,
	input  wire logic [ADDR_W-1:0]      io_addr_i,
	input  wire logic [DATA_W-1:0]      io_wdata_i,
	input  wire logic [CS_W-1:0]        cs_enable_i,
	input  wire logic [CS_W-1:0]        cs_select_i,
	input  wire logic                   address_auto_step_i,
	input  wire logic                   dram_req_i,
	input  wire logic                   dram_dma_i,
	input  wire logic                   dram_wide_i,
	input  wire logic [1:0]             dram_width_i,
	input  wire logic [19:0]            dram_addr_i,
	input  wire logic                   wide_transfer_request_n_i,
	input  wire logic [DATA_W-1:0]      bus_data_i,
	input  wire logic [DRAM_DQ_W-1:0]   dram_dq_i,
	output logic                        busy_o,
	output logic                        done_o,
	output logic                        done_wide_o,
	output logic [DATA_W-1:0]           rdata_o,
	output logic [CS_W-1:0]             chip_select_n_o,
	output logic                        read_strobe_n_o,
	output logic                        write_strobe_n_o,
	output logic [ADDR_W-1:0]           bus_addr_o,
	output logic [DATA_W-1:0]           bus_data_o,
	output logic                        bus_data_oe_o,
	output logic [DRAM_ADDR_W-1:0]      dram_addr_o,
	output logic                        row_strobe_n_o,
	output logic                        column_strobe_n_o
);
	// ==========================================================
	// bus clock enable divider
	logic [2:0]             div_cnt_q;
	logic                   bclk_en;
	logic [2:0]             div_lim;
	seq_state_t             st_q;

	// divisors below two are clamped; the bus clock must be slower than the system clock
	assign div_lim = (bclk_div_i < BCLK_DIV_MIN) ? BCLK_DIV_MIN : bclk_div_i;
	assign bclk_en = (div_cnt_q == 3'h0);

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			div_cnt_q <= 3'h0;
		end else if (st_q == ST_IDLE && (dram_req_i || io_req_i)) begin
			// restart on a take so every cycle step lands a whole bus clock apart
			div_cnt_q <= div_lim - 3'h1;
		end else if (bclk_en) begin
			div_cnt_q <= div_lim - 3'h1;
		end else begin
			div_cnt_q <= div_cnt_q - 3'h1;
		end
	end

	// ==========================================================
	// pin synchronisers
	logic                   io16_meta_q;
	logic                   io16_sync_q;
	logic [DATA_W-1:0]      bus_meta_q;
	logic [DATA_W-1:0]      bus_sync_q;
	logic [DRAM_DQ_W-1:0]   dq_meta_q;
	logic [DRAM_DQ_W-1:0]   dq_sync_q;

	// pins are caught by the first flop at the bus clock edge that samples them
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			io16_meta_q <= 1'b1;
			io16_sync_q <= 1'b1;
			bus_meta_q  <= 16'h0000;
			bus_sync_q  <= 16'h0000;
			dq_meta_q   <= 16'h0000;
			dq_sync_q   <= 16'h0000;
		end else begin
			io16_meta_q <= wide_transfer_request_n_i;
			io16_sync_q <= io16_meta_q;
			bus_meta_q  <= bus_data_i;
			bus_sync_q  <= bus_meta_q;
			dq_meta_q   <= dram_dq_i;
			dq_sync_q   <= dq_meta_q;
		end
	end

	// ==========================================================
	// beats per dram transfer
	function automatic logic [2:0] beats(input logic [1:0] w, input logic wide);
		logic [2:0] n;
		n = 3'h1;
		case (w)
			DRAM_W4:  n = wide ? 3'h4 : 3'h2;
			DRAM_W8:  n = wide ? 3'h2 : 3'h1;
			default:  n = 3'h1;
		endcase
		return n;
	endfunction

	// ==========================================================
	// sequencer
	logic                   wr_q;
	logic                   auto_q;
	logic                   wide_q;
	logic [DATA_W-1:0]      wdata_q;
	logic [1:0]             dw_q;
	logic [2:0]             beat_q;
	logic [2:0]             nbeat_q;
	logic [9:0]             col_q;
	logic [DATA_W-1:0]      acc_q;

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_q <= ST_IDLE;
		end else if (st_q == ST_IDLE) begin
			if (dram_req_i) begin
				st_q <= ST_DR_ROW;
			end else if (io_req_i) begin
				st_q <= ST_IO_SETUP;
			end
		end else if (st_q == ST_DR_END) begin
			st_q <= ST_IDLE;
		end else if (bclk_en) begin
			case (st_q)
				ST_IO_SETUP: st_q <= ST_IO_STRB1;
				ST_IO_STRB1: st_q <= ST_IO_STRB2;
				ST_IO_STRB2: st_q <= ST_IO_HOLD;
				ST_IO_HOLD:  st_q <= ST_IDLE;
				ST_DR_ROW:   st_q <= ST_DR_RAS;
				ST_DR_RAS:   st_q <= ST_DR_COL;
				ST_DR_COL:   st_q <= ST_DR_CAS;
				ST_DR_CAS:   st_q <= ST_DR_LATCH;
				ST_DR_LATCH: st_q <= (beat_q + 3'h1 == nbeat_q) ? ST_DR_END : ST_DR_PRE;
				ST_DR_PRE:   st_q <= ST_DR_CAS;
				default:     st_q <= ST_IDLE;
			endcase
		end
	end

	// request capture
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wr_q     <= 1'b0;
			auto_q   <= 1'b0;
			wdata_q  <= 16'h0000;
			dw_q     <= DRAM_W16;
			nbeat_q  <= 3'h1;
		end else if (st_q == ST_IDLE) begin
			wr_q     <= io_write_i;
			auto_q   <= address_auto_step_i;
			wdata_q  <= io_wdata_i;
			dw_q     <= dram_width_i;
			nbeat_q  <= beats(dram_width_i, dram_wide_i | dram_dma_i & dram_wide_i);
		end
	end

	// sample pipe: a pin is caught by the first flop at the bus clock edge, used two clocks on
	logic [1:0]             smp_q;

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			smp_q <= 2'h0;
		end else begin
			smp_q[0] <= bclk_en && (st_q == ST_IO_SETUP || st_q == ST_IO_STRB2 || st_q == ST_DR_CAS);
			smp_q[1] <= smp_q[0];
		end
	end

	// wide transfer sample at strobe assertion
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wide_q <= 1'b0;
		end else if (smp_q[1] && st_q == ST_IO_STRB1) begin
			wide_q <= !io16_sync_q;
		end else if (st_q == ST_IDLE && dram_req_i) begin
			wide_q <= dram_wide_i;
		end
	end

	// ==========================================================
	// peripheral bus pins
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			chip_select_n_o  <= 4'hF;
			read_strobe_n_o  <= 1'b1;
			write_strobe_n_o <= 1'b1;
		end else if (st_q == ST_IDLE && io_req_i && !dram_req_i) begin
			chip_select_n_o <= ~(cs_select_i & cs_enable_i);
		end else if (st_q == ST_IDLE && dram_req_i) begin
			chip_select_n_o <= 4'hF;
		end else if (st_q == ST_DR_END) begin
			read_strobe_n_o <= 1'b1;
		end else if (bclk_en) begin
			case (st_q)
				ST_IO_SETUP: begin
					read_strobe_n_o  <= wr_q;
					write_strobe_n_o <= !wr_q;
				end
				ST_IO_STRB2: begin
					read_strobe_n_o  <= 1'b1;
					write_strobe_n_o <= 1'b1;
				end
				ST_IO_HOLD:  chip_select_n_o <= 4'hF;
				ST_DR_ROW:   read_strobe_n_o <= 1'b0;
				default:     chip_select_n_o <= chip_select_n_o;
			endcase
		end
	end

	// write data drive window
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			bus_data_o    <= 16'h0000;
			bus_data_oe_o <= 1'b0;
		end else if (bclk_en && st_q == ST_IO_SETUP && wr_q) begin
			bus_data_o    <= wdata_q;
			bus_data_oe_o <= 1'b1;
		end else if (bclk_en && st_q == ST_IO_HOLD) begin
			bus_data_oe_o <= 1'b0;
		end
	end

	// address and auto step
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			bus_addr_o <= 16'h0000;
		end else if (st_q == ST_IDLE && io_req_i && !dram_req_i) begin
			bus_addr_o <= io_addr_i;
		end else if (bclk_en && st_q == ST_IO_HOLD && auto_q) begin
			bus_addr_o <= bus_addr_o + 16'h0001;
		end
	end

	// ==========================================================
	// dram pins and burst
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dram_addr_o       <= 10'h000;
			row_strobe_n_o    <= 1'b1;
			column_strobe_n_o <= 1'b1;
			col_q             <= 10'h000;
			beat_q            <= 3'h0;
		end else if (st_q == ST_IDLE && dram_req_i) begin
			dram_addr_o <= dram_addr_i[19:10];
			col_q       <= dram_addr_i[9:0];
			beat_q      <= 3'h0;
		end else if (bclk_en) begin
			case (st_q)
				ST_DR_ROW:   row_strobe_n_o <= 1'b0;
				ST_DR_RAS:   dram_addr_o <= col_q;
				ST_DR_COL:   column_strobe_n_o <= 1'b0;
				ST_DR_CAS: begin
					col_q       <= col_q + 10'h001;
					dram_addr_o <= col_q + 10'h001;
				end
				ST_DR_LATCH: begin
					column_strobe_n_o <= 1'b1;
					beat_q            <= beat_q + 3'h1;
					if (beat_q + 3'h1 == nbeat_q) begin
						row_strobe_n_o <= 1'b1;
					end
				end
				ST_DR_PRE:   column_strobe_n_o <= 1'b0;
				default:     beat_q <= beat_q;
			endcase
		end
	end

	// data capture: the pin is caught one bus clock after the column strobe, then shifted in
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			acc_q <= 16'h0000;
		end else if (smp_q[1] && st_q == ST_DR_LATCH) begin
			case (dw_q)
				DRAM_W4:  acc_q <= {dq_sync_q[3:0], acc_q[15:4]};
				DRAM_W8:  acc_q <= {dq_sync_q[7:0], acc_q[15:8]};
				default:  acc_q <= dq_sync_q;
			endcase
		end
	end

	// ==========================================================
	// completion
	logic [DATA_W-1:0] packed_rd;

	// narrow beats shift in from the top; right-justify by the real beat count
	always_comb begin
		packed_rd = acc_q;
		case (dw_q)
			DRAM_W4:  packed_rd = (nbeat_q == 3'h4) ? acc_q : {8'h00, acc_q[15:8]};
			DRAM_W8:  packed_rd = (nbeat_q == 3'h2) ? acc_q : {8'h00, acc_q[15:8]};
			default:  packed_rd = acc_q;
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			busy_o      <= 1'b0;
			done_o      <= 1'b0;
			done_wide_o <= 1'b0;
			rdata_o     <= 16'h0000;
		end else begin
			busy_o      <= (st_q != ST_IDLE) || dram_req_i || io_req_i;
			done_o      <= 1'b0;
			if (st_q == ST_DR_END) begin
				done_o      <= 1'b1;
				done_wide_o <= wide_q;
				rdata_o     <= packed_rd;
			end else if (smp_q[1] && st_q == ST_IO_HOLD) begin
				done_o      <= 1'b1;
				done_wide_o <= wide_q;
				rdata_o     <= wide_q ? bus_sync_q : {8'h00, bus_sync_q[7:0]};
			end
		end
	end
endmodule

`default_nettype wire

// ---- pbs_chk.sv ----
/* pbs_chk: pin-level assertions for the bus and dram cycle sequencer.
   assumes bclk_div_i is held at 3, so one bus clock is three system clocks. */
`timescale 1ns/10ps
`default_nettype none
module pbs_chk
	import periph_bus_seq_pkg::*;
(
	input wire logic                 clk_sys_i,
	input wire logic                 resetn_i,
	input wire logic                 address_auto_step_i,
	input wire logic [19:0]          dram_addr_i,
	input wire logic [CS_W-1:0]      chip_select_n_o,
	input wire logic                 read_strobe_n_o,
	input wire logic                 write_strobe_n_o,
	input wire logic [ADDR_W-1:0]    bus_addr_o,
	input wire logic                 bus_data_oe_o,
	input wire logic [DRAM_ADDR_W-1:0] dram_addr_o,
	input wire logic                 row_strobe_n_o,
	input wire logic                 column_strobe_n_o
);
	// ==========================================================
	// helpers
	wire logic cs_on;
	assign cs_on = ~&chip_select_n_o;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);
	// two bus clocks low, then high
	sequence s_pulse(s); (!s)[*6] ##1 s; endsequence
	// one bus clock more, then gone
	sequence s_hold(s); s[*3] ##1 !s; endsequence
	// ==========================================================
	// assertions
	a_cs_lead: assert property (($fell(read_strobe_n_o) || $fell(write_strobe_n_o)) && cs_on |->
		$past(cs_on, 3) && !$past(cs_on, 4)) else $error("select did not lead strobe by one bus clock");
	a_rd_width: assert property ($fell(read_strobe_n_o) && cs_on |-> s_pulse(read_strobe_n_o))
		else $error("read strobe width wrong");
	a_cs_tail: assert property (($rose(read_strobe_n_o) || $rose(write_strobe_n_o)) && cs_on |->
		s_hold(cs_on)) else $error("select tail wrong");
	a_wr_width: assert property ($fell(write_strobe_n_o) |-> s_pulse(write_strobe_n_o))
		else $error("write strobe width wrong");
	a_wdata_lead: assert property ($rose(bus_data_oe_o) |-> $fell(write_strobe_n_o))
		else $error("write data not with strobe");
	a_wdata_hold: assert property ($rose(write_strobe_n_o) |-> s_hold(bus_data_oe_o))
		else $error("write data hold wrong");
	a_addr_step: assert property (($rose(read_strobe_n_o) || $rose(write_strobe_n_o)) && cs_on |->
		$stable(bus_addr_o)[*3] ##1 bus_addr_o == $past(bus_addr_o) + (address_auto_step_i ? 16'h0001 : 16'h0000))
		else $error("address step wrong");
	a_row_col: assert property ($fell(row_strobe_n_o) |-> !read_strobe_n_o && dram_addr_o == dram_addr_i[19:10]
		&& $past(dram_addr_o, 3) == dram_addr_i[19:10] ##3 dram_addr_o == dram_addr_i[9:0])
		else $error("row to column sequence wrong");
	a_col_step: assert property ($fell(column_strobe_n_o) |-> $past(dram_addr_o, 3) == dram_addr_o
		##3 dram_addr_o == $past(dram_addr_o, 3) + 10'h001) else $error("column strobe or step wrong");
	a_cas_width: assert property ($fell(column_strobe_n_o) |-> s_pulse(column_strobe_n_o))
		else $error("column strobe width wrong");
	a_cas_gap: assert property ($rose(column_strobe_n_o) |-> column_strobe_n_o[*3]
		##1 (!column_strobe_n_o || row_strobe_n_o))
		else $error("column precharge too short");
	a_rd_release: assert property ($rose(row_strobe_n_o) |-> column_strobe_n_o ##1 read_strobe_n_o)
		else $error("read strobe late after address strobes");
endmodule
bind periph_bus_dram_cycle_seq pbs_chk pbs_chk_inst (.clk_sys_i, .resetn_i, .address_auto_step_i, .dram_addr_i,
	.chip_select_n_o, .read_strobe_n_o, .write_strobe_n_o, .bus_addr_o, .bus_data_oe_o, .dram_addr_o,
	.row_strobe_n_o, .column_strobe_n_o);
`default_nettype wire

// ---- pbs_partner.sv ----
/* pbs_partner: a peripheral and a dram buffer on the far side of the sequencer.
   assumes the testbench picks peripheral data, width and dram latency. */
`timescale 1ns/10ps
`default_nettype none
module pbs_partner (
	input wire logic        sel_n_i,
	input wire logic        rd_n_i,
	input wire logic        ras_n_i,
	input wire logic        cas_n_i,
	input wire logic [9:0]  ma_i,
	input wire logic        wide_i,
	input wire logic        slow_i,
	input wire logic [15:0] pdata_i,
	output logic [15:0]     pdata_o,
	output logic            wide_n_o,
	output logic [15:0]     dq_o
);
	// ==========================================================
	// peripheral: undriven lines show the inverse, not stale data
	logic [9:0]  row_q;
	logic [15:0] v;
	assign pdata_o = !rd_n_i ? pdata_i : ~pdata_i;
	assign wide_n_o = !(wide_i && !sel_n_i);
	// ==========================================================
	// dram cell pattern, column latched at strobe fall
	initial dq_o = 16'h0000;
	always @(negedge ras_n_i) row_q = ma_i;
	always @(negedge cas_n_i) begin
		v = {row_q[7:0], ma_i[7:0]} ^ 16'h3c5a;
		#(slow_i ? 45 : 2) dq_o = v;
	end
	always @(posedge cas_n_i) dq_o = ~dq_o;
endmodule
`default_nettype wire

// ---- tb_top.sv ----
/* tb_top: self-checking bench for the sequencer with the far-side model.
   assumes one bus clock of three system clocks at 50 MHz. */
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import periph_bus_seq_pkg::*;
;
	// ==========================================================
	// signals
	logic clk_sys_i = 0, resetn_i = 0, io_req_i = 0, io_write_i = 0, address_auto_step_i = 0;
	logic dram_req_i = 0, dram_dma_i = 0, dram_wide_i = 0, pwide = 0, slow = 0;
	logic [15:0] io_addr_i = 0, io_wdata_i = 0, pdat = 0, rdata_o, bus_addr_o, bus_data_o;
	logic [3:0] cs_enable_i = 0, cs_select_i = 0, chip_select_n_o;
	logic [1:0] dram_width_i = 0;
	logic [19:0] dram_addr_i = 0;
	logic [9:0] dram_addr_o;
	logic busy_o, done_o, done_wide_o, read_strobe_n_o, write_strobe_n_o, bus_data_oe_o;
	logic row_strobe_n_o, column_strobe_n_o;
	wire logic wide_transfer_request_n_i;
	wire logic [15:0] bus_data_i, dram_dq_i;
	int errors = 0, comparisons = 0, column_strobe_n = 0;
	always #10 clk_sys_i = ~clk_sys_i;
	always @(negedge column_strobe_n_o) column_strobe_n++;
	periph_bus_dram_cycle_seq periph_bus_dram_cycle_seq_inst (.clk_sys_i, .resetn_i, .bclk_div_i(3'h3),
		.io_req_i, .io_write_i, .io_addr_i, .io_wdata_i, .cs_enable_i, .cs_select_i, .address_auto_step_i,
		.dram_req_i, .dram_dma_i, .dram_wide_i, .dram_width_i, .dram_addr_i, .wide_transfer_request_n_i,
		.bus_data_i, .dram_dq_i, .busy_o, .done_o, .done_wide_o, .rdata_o, .chip_select_n_o, .read_strobe_n_o,
		.write_strobe_n_o, .bus_addr_o, .bus_data_o, .bus_data_oe_o, .dram_addr_o, .row_strobe_n_o,
		.column_strobe_n_o);
	pbs_partner pbs_partner_inst (.sel_n_i(&chip_select_n_o), .rd_n_i(read_strobe_n_o), .ras_n_i(row_strobe_n_o),
		.cas_n_i(column_strobe_n_o), .ma_i(dram_addr_o), .wide_i(pwide), .slow_i(slow), .pdata_i(pdat),
		.pdata_o(bus_data_i), .wide_n_o(wide_transfer_request_n_i), .dq_o(dram_dq_i));
	// ==========================================================
	// tasks
	task report_and_stop;
		if (errors == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(string n, logic [15:0] e, logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	// bounded wait at falling edges, where outputs have settled
	task automatic wait_lvl(ref logic s, input logic v);
		int n = 0;
		while (s !== v) begin
			@(negedge clk_sys_i);
			if (++n > 300) begin
				errors++;
				report_and_stop;
			end
		end
	endtask
	task automatic io(logic w, logic s, logic wd);
		io_write_i = w; address_auto_step_i = s; pwide = wd;
		io_addr_i = $urandom; io_wdata_i = $urandom; pdat = $urandom;
		cs_enable_i = 4'($urandom) | 4'h1; cs_select_i = 4'($urandom) | 4'h1;
		io_req_i = 1;
		wait_lvl(busy_o, 1);
		@(negedge clk_sys_i) io_req_i = 0;
		if (w) wait_lvl(write_strobe_n_o, 0); else wait_lvl(read_strobe_n_o, 0);
		chk("select", {12'h000, ~(cs_enable_i & cs_select_i)}, {12'h000, chip_select_n_o});
		if (w) chk("wdata", io_wdata_i, bus_data_o);
		wait_lvl(done_o, 1);
		chk("wide", {15'h0000, wd}, {15'h0000, done_wide_o});
		if (!w) chk("rdata", wd ? pdat : {8'h00, pdat[7:0]}, rdata_o);
		wait_lvl(busy_o, 0);
		chk("addr", io_addr_i + {15'h0000, s}, bus_addr_o);
	endtask
	task automatic dram(logic [1:0] w, logic wd, logic dma, logic sl);
		logic [15:0] e = 0;
		logic [15:0] c;
		int n;
		dram_width_i = w; dram_wide_i = wd; dram_dma_i = dma; slow = sl; column_strobe_n = 0;
		dram_addr_i = {10'($urandom), 10'($urandom_range(0, 1000))};
		n = (w == 0) ? (wd ? 4 : 2) : (w == 1) ? (wd ? 2 : 1) : 1;
		for (int k = 0; k < n; k++) begin
			c = {dram_addr_i[17:10], 8'(dram_addr_i[7:0] + k)} ^ 16'h3c5a;
			e |= (w == 0) ? {12'h000, c[3:0]} << (4 * k) : (w == 1) ? {8'h00, c[7:0]} << (8 * k) : c;
		end
		dram_req_i = 1;
		wait_lvl(busy_o, 1);
		@(negedge clk_sys_i) dram_req_i = 0;
		wait_lvl(done_o, 1);
		c = wd ? 16'hffff : 16'h00ff;
		chk("dram", e & c, rdata_o & c);
		chk("beats", 16'(n), 16'(column_strobe_n));
		chk("dwide", {15'h0000, wd}, {15'h0000, done_wide_o});
		wait_lvl(busy_o, 0);
	endtask
	// ==========================================================
	// sequence
	initial begin
		void'($urandom(32'h9182d990));
		repeat (16) @(negedge clk_sys_i);
		resetn_i = 1;
		io(1, 1, 1); io(1, 0, 0); io(0, 1, 1); io(0, 0, 0);
		for (int i = 0; i < 16; i++)
			dram(2'(i), i[2], i[3], i[0] ^ i[3]);
		// reset in mid-burst must return every select, strobe and the data enable to idle
		dram_width_i = 0; dram_wide_i = 1; dram_req_i = 1;
		wait_lvl(busy_o, 1);
		repeat (12) @(negedge clk_sys_i);
		resetn_i = 0; dram_req_i = 0;
		@(negedge clk_sys_i);
		chk("idle", 16'h03de, {6'h00, chip_select_n_o, bus_data_oe_o, row_strobe_n_o, column_strobe_n_o,
			read_strobe_n_o, write_strobe_n_o, busy_o});
		resetn_i = 1;
		io(0, 1, 0);
		report_and_stop;
	end
endmodule
`default_nettype wire
